//--- core/rcap_pkg.sv
package rcap_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL       = 8'h16;
    localparam logic [7:0] IDX_WINDOW     = 8'h17;
    localparam logic [7:0] IDX_PEAK       = 8'h18;
    localparam logic [7:0] IDX_THRESH     = 8'h19;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h1E;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h1F;

    // Control register fields
    localparam int CTRL_SEND_BIT   = 11;
    localparam int CTRL_WIDTH_LSB  = 8;
    localparam int CTRL_MODE_BIT   = 7;
    localparam int CTRL_THR_LSB    = 0;
    localparam logic [15:0] CTRL_RESET    = 16'h0020;
    localparam logic [15:0] CTRL_WR_MASK  = 16'hF7BF;

    // Window register fields
    localparam int WIN_START_LSB = 8;
    localparam int WIN_STOP_LSB  = 0;
    localparam logic [15:0] WIN_RESET = 16'h0000;

    // Result register fields
    localparam int PEAK_VALUE_LSB = 8;
    localparam int THR_MET_BIT    = 8;

    // Interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_THR_BIT  = 1;
    localparam int IRQ_BITS     = 2;

    // Timing: one window tick per sample clock
    localparam int TICK_NS    = 8;
    localparam int CLK_NS     = 8;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [5:0] SAMPLE_ZERO = 6'h20;
    localparam logic [7:0] TIME_MAX    = 8'hFF;

    typedef struct packed {
        logic [5:0] peak_sample_value;
        logic [7:0] peak_first_time;
        logic       threshold_met_flag;
        logic [7:0] threshold_first_time;
    } rcap_result_t;

    localparam rcap_result_t RESULT_RESET = '0;

endpackage

//--- core/rcap_top.sv
`timescale 1ns/100ps

// Function
// RULE_01 - Window start and stop count in 8 ns ticks from the launched pulse.
// RULE_02 - Window start in bits 15:8, stop in 7:0; sample only between them.
// RULE_03 - Software sets stop not below start before launching.
// RULE_04 - Positive mode: threshold met only when sample strictly above threshold.
// RULE_05 - Negative mode: threshold met only when sample strictly below threshold.
// RULE_06 - Samples and threshold are 6-bit offset codes, 0x20 meaning zero.
// RULE_07 - Peak field 13:8 holds window maximum, or minimum in negative mode.
// RULE_08 - Peak time 7:0 is first occurrence; equal later samples keep it.
// RULE_09 - Threshold-met flag at bit 8 set if any window sample met threshold.
// RULE_10 - Threshold time 7:0 records first sample meeting threshold.
// RULE_11 - Results valid once pulse-send bit 11 returns to zero.
// RULE_12 - Reserved result bits ignore writes and read zero.
// RULE_13 - Setting pulse-send launches one pulse, arms capture, self-clears at end.
// RULE_14 - Mode bit 7 selects positive peak at 0, negative peak at 1.
// RULE_15 - Each launch clears flag, times, peak tracker and window counter.
// RULE_16 - Window counter saturates at 255; capture ends past stop time.
module rcap_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  rx_sample,
    output logic             pulse_launch,
    output logic      [2:0]  pulse_width,
    output logic             irq
);

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    logic [15:0]                 ctrl;
    logic [15:0]                 window;
    logic [rcap_pkg::IRQ_BITS-1:0] irq_status;
    logic [rcap_pkg::IRQ_BITS-1:0] irq_mask;
    rcap_pkg::rcap_result_t      result;
    logic                        busy;
    logic [7:0]                  win_time;
    logic                        peak_seen;
    logic                        setup;
    logic                        access;
    logic                        wr_en;
    logic [7:0]                  idx;
    logic                        mapped;
    logic                        launch_req;
    logic                        in_win;
    logic                        thr_hit;
    logic                        peak_better;
    logic                        mode_neg;
    logic [5:0]                  thr;
    logic [7:0]                  win_start;
    logic [7:0]                  win_stop;
    logic [15:0]                 next_rdata;
    logic                        done_evt;
    logic                        thr_evt;

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign idx    = paddr[9:2];
    assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                    (idx == rcap_pkg::IDX_CTRL || idx == rcap_pkg::IDX_WINDOW ||
                     idx == rcap_pkg::IDX_PEAK || idx == rcap_pkg::IDX_THRESH ||
                     idx == rcap_pkg::IDX_IRQ_STATUS || idx == rcap_pkg::IDX_IRQ_MASK);
    assign wr_en  = access && pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    assign launch_req = wr_en && idx == rcap_pkg::IDX_CTRL &&
                        pwdata[rcap_pkg::CTRL_SEND_BIT] && !busy; // [RULE_13]

    // Read data is latched in the setup cycle so it is stable in access
    always_comb begin
        next_rdata = 16'h0000;
        unique case (idx)
            rcap_pkg::IDX_CTRL: begin
                next_rdata = ctrl;
                next_rdata[rcap_pkg::CTRL_SEND_BIT] = busy; // [RULE_11]
            end
            rcap_pkg::IDX_WINDOW:     next_rdata = window;
            // Reserved bits fall out of the zero fill [RULE_12]
            rcap_pkg::IDX_PEAK:       next_rdata = {2'h0, result.peak_sample_value,
                                                    result.peak_first_time};
            rcap_pkg::IDX_THRESH:     next_rdata = {7'h00, result.threshold_met_flag,
                                                    result.threshold_first_time};
            rcap_pkg::IDX_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
            rcap_pkg::IDX_IRQ_MASK:   next_rdata = {14'h0000, irq_mask};
            default:                  next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= {16'h0000, mapped ? next_rdata : 16'h0000};
        end
    end

    // ----------------------------------------------------------------
    // Control and window registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= rcap_pkg::CTRL_RESET;
        end else if (wr_en && idx == rcap_pkg::IDX_CTRL) begin
            // Send bit lives in busy; reserved bit 6 is held at zero
            ctrl <= pwdata[15:0] & rcap_pkg::CTRL_WR_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window <= rcap_pkg::WIN_RESET;
        end else if (wr_en && idx == rcap_pkg::IDX_WINDOW) begin
            window <= pwdata[15:0];
        end
    end

    assign win_start   = window[rcap_pkg::WIN_START_LSB +: 8]; // [RULE_02]
    assign win_stop    = window[rcap_pkg::WIN_STOP_LSB +: 8];
    assign thr         = ctrl[rcap_pkg::CTRL_THR_LSB +: 6];
    assign pulse_width = ctrl[rcap_pkg::CTRL_WIDTH_LSB +: 3];

    // ----------------------------------------------------------------
    // Launch and window timer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_launch <= 1'b0;
        end else begin
            pulse_launch <= launch_req; // [RULE_13]
        end
    end

    // Mode is frozen per capture so a mid-window write cannot mix criteria
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_neg <= 1'b0;
        end else if (launch_req) begin
            mode_neg <= pwdata[rcap_pkg::CTRL_MODE_BIT]; // [RULE_14]
        end
    end

    // One tick per cycle at the 8 ns clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy     <= 1'b0;
            win_time <= 8'h00;
        end else if (launch_req) begin
            busy     <= 1'b1;
            win_time <= 8'h00; // [RULE_15] [RULE_01]
        end else if (busy) begin
            if (win_time == win_stop) begin
                busy <= 1'b0; // [RULE_16] [RULE_13]
            end
            if (win_time != rcap_pkg::TIME_MAX) begin
                win_time <= win_time + 8'h01; // [RULE_16]
            end
        end
    end

    // A stop below start gives an empty window and a quick finish
    assign in_win = busy && win_time >= win_start && win_time <= win_stop; // [RULE_02]

    // ----------------------------------------------------------------
    // Peak and threshold capture
    // ----------------------------------------------------------------
    // Offset codes compare correctly as unsigned values [RULE_06]
    assign thr_hit     = mode_neg ? (rx_sample < thr) : (rx_sample > thr); // [RULE_04] [RULE_05]
    assign peak_better = !peak_seen ||
                         (mode_neg ? (rx_sample < result.peak_sample_value)
                                   : (rx_sample > result.peak_sample_value)); // [RULE_07]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result    <= rcap_pkg::RESULT_RESET;
            peak_seen <= 1'b0;
        end else if (launch_req) begin
            result    <= rcap_pkg::RESULT_RESET; // [RULE_15]
            peak_seen <= 1'b0;
        end else if (in_win) begin
            peak_seen <= 1'b1;
            if (peak_better) begin
                // Strict compare keeps the first time on ties [RULE_08]
                result.peak_sample_value <= rx_sample;
                result.peak_first_time   <= win_time;
            end
            if (thr_hit && !result.threshold_met_flag) begin
                result.threshold_met_flag   <= 1'b1; // [RULE_09]
                result.threshold_first_time <= win_time; // [RULE_10]
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign done_evt = busy && win_time == win_stop && !launch_req;
    assign thr_evt  = in_win && thr_hit && !result.threshold_met_flag && !launch_req;

    // A new event wins over a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else begin
            for (int i = 0; i < rcap_pkg::IRQ_BITS; i++) begin
                if ((i == rcap_pkg::IRQ_DONE_BIT && done_evt) ||
                    (i == rcap_pkg::IRQ_THR_BIT && thr_evt)) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_en && idx == rcap_pkg::IDX_IRQ_STATUS && pwdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_en && idx == rcap_pkg::IDX_IRQ_MASK) begin
            irq_mask <= pwdata[rcap_pkg::IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status() & irq_mask);
        end
    end

    function automatic logic [rcap_pkg::IRQ_BITS-1:0] next_irq_status();
        logic [rcap_pkg::IRQ_BITS-1:0] s;
        s = irq_status;
        return s;
    endfunction

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_launch_clears;
        @(posedge pclk) disable iff (!presetn)
        launch_req |=> busy && win_time == 8'h00 && !result.threshold_met_flag &&
                       result.threshold_first_time == 8'h00 && result.peak_first_time == 8'h00;
    endproperty
    a_launch_clears: assert property (p_launch_clears) else $error("launch did not clear capture"); // [RULE_15]

    property p_launch_pulse;
        @(posedge pclk) disable iff (!presetn)
        launch_req |=> pulse_launch ##1 !pulse_launch;
    endproperty
    a_launch_pulse: assert property (p_launch_pulse) else $error("launch pulse not one cycle"); // [RULE_13]

    property p_tick_count;
        @(posedge pclk) disable iff (!presetn)
        busy && !launch_req && win_time != win_stop && win_time != 8'hFF
        |=> win_time == $past(win_time) + 8'h01;
    endproperty
    a_tick_count: assert property (p_tick_count) else $error("window time did not advance"); // [RULE_01]

    property p_saturate;
        @(posedge pclk) disable iff (!presetn)
        busy && win_time == 8'hFF && !launch_req |=> win_time == 8'hFF;
    endproperty
    a_saturate: assert property (p_saturate) else $error("window time wrapped"); // [RULE_16]

    property p_end_at_stop;
        @(posedge pclk) disable iff (!presetn)
        busy && win_time == win_stop && !launch_req |=> !busy && irq_status[rcap_pkg::IRQ_DONE_BIT];
    endproperty
    a_end_at_stop: assert property (p_end_at_stop) else $error("capture did not end"); // [RULE_16]

    property p_thr_pos;
        @(posedge pclk) disable iff (!presetn)
        in_win && !launch_req && !mode_neg && rx_sample > thr && !result.threshold_met_flag
        |=> result.threshold_met_flag && result.threshold_first_time == $past(win_time);
    endproperty
    a_thr_pos: assert property (p_thr_pos) else $error("positive threshold missed"); // [RULE_04]

    property p_thr_neg;
        @(posedge pclk) disable iff (!presetn)
        in_win && !launch_req && mode_neg && rx_sample >= thr && !result.threshold_met_flag
        |=> !result.threshold_met_flag;
    endproperty
    a_thr_neg: assert property (p_thr_neg) else $error("negative threshold falsely met"); // [RULE_05]

    property p_outside_window;
        @(posedge pclk) disable iff (!presetn)
        !in_win && !launch_req |=> $stable(result);
    endproperty
    a_outside_window: assert property (p_outside_window) else $error("capture outside window"); // [RULE_02]

    property p_peak_tie;
        @(posedge pclk) disable iff (!presetn)
        in_win && !launch_req && peak_seen && rx_sample == result.peak_sample_value
        |=> $stable(result.peak_first_time);
    endproperty
    a_peak_tie: assert property (p_peak_tie) else $error("peak time moved on a tie"); // [RULE_08]

    property p_peak_max;
        @(posedge pclk) disable iff (!presetn)
        in_win && !launch_req && !mode_neg && peak_seen && rx_sample > result.peak_sample_value
        |=> result.peak_sample_value == $past(rx_sample);
    endproperty
    a_peak_max: assert property (p_peak_max) else $error("maximum not tracked"); // [RULE_07]

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == {2'h0, rcap_pkg::IDX_THRESH, 2'h0} |-> prdata[31:9] == 23'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero"); // [RULE_12]

    property p_peak_min;
        @(posedge pclk) disable iff (!presetn)
        in_win && !launch_req && mode_neg && peak_seen && rx_sample < result.peak_sample_value
        |=> result.peak_sample_value == $past(rx_sample);
    endproperty
    a_peak_min: assert property (p_peak_min) else $error("minimum not tracked"); // [RULE_07]

    property p_thr_neg_hit;
        @(posedge pclk) disable iff (!presetn)
        in_win && !launch_req && mode_neg && rx_sample < thr && !result.threshold_met_flag
        |=> result.threshold_met_flag && result.threshold_first_time == $past(win_time);
    endproperty
    a_thr_neg_hit: assert property (p_thr_neg_hit) else $error("threshold missed"); // [RULE_05]

    property p_thr_sticky;
        @(posedge pclk) disable iff (!presetn)
        result.threshold_met_flag && !launch_req
        |=> result.threshold_met_flag && $stable(result.threshold_first_time);
    endproperty
    a_thr_sticky: assert property (p_thr_sticky) else $error("threshold time moved"); // [RULE_10]

    property p_no_relaunch;
        @(posedge pclk) disable iff (!presetn)
        busy && wr_en && idx == rcap_pkg::IDX_CTRL && pwdata[rcap_pkg::CTRL_SEND_BIT]
        |=> !pulse_launch;
    endproperty
    a_no_relaunch: assert property (p_no_relaunch) else $error("launch while busy"); // [RULE_13]

endmodule

//--- tb/rcap_echo_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Cable echo: replays a table from launch
// ----------------------------------------
module rcap_echo_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       pulse_launch,
    output logic      [5:0] rx_sample
);
    logic [5:0] wave [256];
    logic [7:0] t;
    logic       live;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t    <= 8'h00;
            live <= 1'b0;
        end else if (pulse_launch) begin
            t    <= 8'h01;
            live <= 1'b1;
        end else if (live) begin
            t    <= t + 8'h01;
            live <= (t != 8'hFF);
        end
    end

    // Time zero rides with the launch cycle; a quiet pair sits at offset zero
    assign rx_sample = pulse_launch ? wave[0] : (live ? wave[t] : 6'h20);
endmodule

//--- tb/rcap_top_tb_top.sv
`timescale 1ns/100ps
module rcap_top_tb_top;
    typedef struct {logic [32:0] v; bit care; string n;} rcap_note_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pulse_launch;
    logic        irq;
    logic [2:0]  pulse_width;
    logic [5:0]  rx_sample;
    int          n_errors = 0;
    int          tests_run = 0;
    int          launches = 0;
    rcap_note_t  nq [$];
    rcap_note_t  nt;
    logic [7:0]  st;
    logic [7:0]  sp;

    always #4 pclk = ~pclk;

    rcap_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_sample(rx_sample), .pulse_launch(pulse_launch),
        .pulse_width(pulse_width), .irq(irq));
    rcap_echo_model u_echo (.pclk(pclk), .presetn(presetn), .pulse_launch(pulse_launch),
        .rx_sample(rx_sample));

    task automatic chk(input string n, input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // --------------------------------
    // Read results compared as they land
    // --------------------------------
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && nq.size() > 0) begin
            nt = nq.pop_front();
            if (nt.care) chk(nt.n, {pslverr, prdata}, nt.v);
        end
        if (pulse_launch === 1'b1) launches++;
    end

    task automatic apb(input logic w, input logic [7:0] ix, input logic [15:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'b00, ix, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ix, input logic [15:0] d);
        logic [31:0] q;
        apb(1'b1, ix, d, q);
    endtask

    task automatic rd(input logic [7:0] ix, input logic [32:0] e, input string n, input bit c = 1);
        logic [31:0] q;
        nq.push_back('{e, c, n});
        apb(1'b0, ix, 16'h0000, q);
    endtask

    // --------------------------------
    // One launch and its full readout
    // --------------------------------
    task automatic capture(input logic [7:0] s0, input logic [7:0] s1, input logic mode,
                           input logic [5:0] thr, input logic [1:0] msk, input bit again);
        logic [15:0] c;
        logic [5:0]  pk;
        logic [5:0]  s;
        logic [7:0]  pt;
        logic [7:0]  tt;
        logic [31:0] q;
        logic        met;
        bit          any;
        int          l0;
        int          g;
        c = {4'($urandom), 1'b1, 3'($urandom), mode, 1'b0, thr};
        for (int i = 0; i < 256; i++) u_echo.wave[i] = 6'($urandom);
        any = 0;
        met = 1'b0;
        pk = 6'h00;
        pt = 8'h00;
        tt = 8'h00;
        for (int t = s0; t <= s1; t++) begin
            s = u_echo.wave[t];
            if (!any || (mode ? s < pk : s > pk)) begin
                pk = s;
                pt = 8'(t);
            end
            if (!met && (mode ? s < thr : s > thr)) begin
                met = 1'b1;
                tt = 8'(t);
            end
            any = 1;
        end
        wr(rcap_pkg::IDX_WINDOW, {s0, s1});
        wr(rcap_pkg::IDX_IRQ_MASK, {14'h0, msk});
        l0 = launches;
        wr(rcap_pkg::IDX_CTRL, c);
        if (again) wr(rcap_pkg::IDX_CTRL, c);
        chk("pulse width", pulse_width, c[10:8]);
        g = 0;
        do begin
            nq.push_back('{33'h0, 1'b0, "poll"});
            apb(1'b0, rcap_pkg::IDX_CTRL, 16'h0000, q);
            g++;
        end while (q[rcap_pkg::CTRL_SEND_BIT] !== 1'b0 && g < 200);
        chk("send cleared", 33'(q[rcap_pkg::CTRL_SEND_BIT]), 33'h0);
        chk("launch count", 33'(launches - l0), 33'h1);
        rd(rcap_pkg::IDX_CTRL, {17'h0, c & rcap_pkg::CTRL_WR_MASK}, "ctrl");
        rd(rcap_pkg::IDX_PEAK, {19'h0, pk, pt}, "peak");
        rd(rcap_pkg::IDX_THRESH, {24'h0, met, tt}, "thresh");
        rd(rcap_pkg::IDX_IRQ_STATUS, {31'h0, met, 1'b1}, "irq status");
        chk("irq", irq, |({met, 1'b1} & msk));
        wr(rcap_pkg::IDX_IRQ_STATUS, 16'h0003);
        rd(rcap_pkg::IDX_IRQ_STATUS, 33'h0, "irq status");
        chk("irq", irq, 1'b0);
    endtask

    initial begin
        #400000;
        n_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(23806));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(rcap_pkg::IDX_CTRL, {17'h0, rcap_pkg::CTRL_RESET}, "ctrl reset");
        rd(rcap_pkg::IDX_WINDOW, 33'h0, "window reset");
        rd(rcap_pkg::IDX_IRQ_MASK, 33'h0, "mask reset");
        rd(8'h10, {1'b1, 32'h0}, "unmapped");
        wr(rcap_pkg::IDX_PEAK, 16'hFFFF);
        wr(rcap_pkg::IDX_THRESH, 16'hFFFF);
        rd(rcap_pkg::IDX_PEAK, 33'h0, "peak ro");
        rd(rcap_pkg::IDX_THRESH, 33'h0, "thresh ro");
        wr(rcap_pkg::IDX_WINDOW, 16'hA55A);
        rd(rcap_pkg::IDX_WINDOW, 33'h0A55A, "window");
        // Window running to the saturation point, with a refused second launch
        capture(8'hF0, 8'hFF, 1'b0, 6'h20, 2'b11, 1);
        capture(8'h00, 8'h00, 1'b1, 6'h20, 2'b01, 0);
        for (int k = 0; k < 6; k++) begin
            st = 8'($urandom);
            sp = (st > 8'hD7) ? 8'hFF : st + 8'($urandom_range(40, 0));
            capture(st, sp, k[0], 6'($urandom), 2'($urandom), sp >= 8'h10);
        end
        complete_run();
    end
endmodule
